// *** pkg/usb_buf_pkg.sv ***
// constants shared by the endpoint buffer control block
// assumes a single 20 MHz core clock and a synchronous active-low reset
package usb_buf_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int NUM_EP = 16;
    localparam int EP_W = 4;
    localparam int LEN_W = 10;
    localparam int HALF_W = 16;
    localparam int DONE_BIT = 15;
    localparam int PKT_W = 7;
    localparam logic [PKT_W-1:0] LS_MAX_PKT = 7'h08;
    localparam logic [PKT_W-1:0] FS_MAX_PKT = 7'h40;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam int POLL_UNIT_US = 1000;
    localparam int POLL_UNIT_CYCLES = CLK_HZ / 1_000_000 * POLL_UNIT_US;
    localparam logic [7:0] INTERVAL_RESET = 8'h00;

    typedef enum logic [1:0] {
        HOST_IDLE = 2'b00,
        HOST_FETCH = 2'b01,
        HOST_PACKET = 2'b10,
        HOST_DONE = 2'b11
    } host_state_e;
endpackage : usb_buf_pkg

// *** hw/usb_poll_tick.sv ***
// divider giving a one-cycle enable per polling time unit
// assumes it runs on the core clock of the buffer control block
module usb_poll_tick #(
    parameter int CYCLES = usb_buf_pkg::POLL_UNIT_CYCLES
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // control
    input wire logic i_enable,
    // enable pulse out
    output logic o_tick
);
    import usb_buf_pkg::*;

    localparam int CNT_W = $clog2(CYCLES + 1);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

    logic [CNT_W-1:0] count_reg;

    // free count while enabled; restarting on disable keeps intervals whole
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n || !i_enable) begin
            count_reg <= '0;
            o_tick <= 1'b0;
        end else if (count_reg == LAST) begin
            count_reg <= '0;
            o_tick <= 1'b1;
        end else begin
            count_reg <= count_reg + 1'b1;
            o_tick <= 1'b0;
        end
    end
endmodule : usb_poll_tick

// *** hw/usb_endpoint_buffer_control.sv ***
// endpoint buffer bookkeeping: device-side abort, host-side buffer select
// assumes token and packet strobes synchronous to i_core_clk
// Function
// - device: an endpoint's abort bit cancels its pending transactions.
// - token on an aborted endpoint naks only it, never locks others.
// - host runs software transfers and self-timed interrupt endpoint polls.
// - interrupt transfers single buffered; selector reset to first buffer.
// - selector alternates only in double-buffered mode, else stays on first.
// - split transfers into packets of 8 bytes low speed, 64 full speed.
// - second buffer status is upper 16 bits; single mode writes lower only.
// - single mode fetches buffer info from first buffer fields regardless.
// - at buffer done, record the selector in the handling status output.
module usb_endpoint_buffer_control #(
    parameter int POLL_CYCLES = usb_buf_pkg::POLL_UNIT_CYCLES
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // device role: software abort and arm, bus tokens
    input wire logic [usb_buf_pkg::NUM_EP-1:0] i_endpoint_abort_bits,
    input wire logic [usb_buf_pkg::NUM_EP-1:0] i_ep_arm,
    input wire logic i_tok_valid,
    input wire logic [usb_buf_pkg::EP_W-1:0] i_tok_ep,
    output logic o_resp_valid,
    output logic o_resp_nak,
    output logic [usb_buf_pkg::NUM_EP-1:0] o_ep_pending,
    // host role: configuration
    input wire logic i_full_speed,
    input wire logic i_double_buf,
    input wire logic i_int_enable,
    input wire logic [7:0] i_int_interval,
    input wire logic [31:0] i_buf_ctrl,
    // host role: software start and status clear
    input wire logic i_host_start,
    input wire logic i_status_clear,
    // host role: packet handshake with the link
    output logic o_pkt_valid,
    output logic [usb_buf_pkg::PKT_W-1:0] o_pkt_len,
    input wire logic i_pkt_done,
    // host role: completion
    output logic o_buf_done,
    output logic o_busy,
    output logic o_is_int,
    output logic [31:0] o_buf_status,
    output logic o_buffer_handling_selector_status
);
    import usb_buf_pkg::*;

    localparam int IVL_W = 8;

    // device role state
    logic [NUM_EP-1:0] pending_reg;
    // host role state
    host_state_e state_reg;
    logic sel_reg;
    logic is_int_reg;
    logic [LEN_W-1:0] remain_reg;
    logic [IVL_W-1:0] frame_cnt_reg;
    logic int_due_reg;
    logic poll_tick;
    logic use_double;
    logic [PKT_W-1:0] max_pkt;
    logic [LEN_W-1:0] pkt_len_wide;
    logic [LEN_W-1:0] remain_next;

    // per-endpoint pending flag; abort is a level and beats arm and use
    for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
        always_ff @(posedge i_core_clk) begin
            if (!i_reset_n) begin
                pending_reg[e] <= 1'b0;
            end else if (i_endpoint_abort_bits[e]) begin
                pending_reg[e] <= 1'b0;
            end else if (i_ep_arm[e]) begin
                pending_reg[e] <= 1'b1;
            end else if (i_tok_valid && i_tok_ep == EP_W'(e)) begin
                pending_reg[e] <= 1'b0;
            end
        end
    end
    assign o_ep_pending = pending_reg;

    // token answer depends only on the addressed endpoint, so an aborted
    // endpoint cannot leave a global nak state behind
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_resp_valid <= 1'b0;
            o_resp_nak <= 1'b0;
        end else begin
            o_resp_valid <= i_tok_valid;
            o_resp_nak <= i_tok_valid && (i_endpoint_abort_bits[i_tok_ep] ||
                !pending_reg[i_tok_ep]);
        end
    end

    // polling time base
    usb_poll_tick #(
        .CYCLES(POLL_CYCLES)
    ) u_tick (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_enable(i_int_enable),
        .o_tick(poll_tick)
    );

    // interval counter; due flag set wins over its clear at transfer start
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n || !i_int_enable) begin
            frame_cnt_reg <= INTERVAL_RESET;
            int_due_reg <= 1'b0;
        end else if (poll_tick && frame_cnt_reg + 1'b1 >= i_int_interval) begin
            frame_cnt_reg <= INTERVAL_RESET;
            int_due_reg <= 1'b1;
        end else begin
            if (poll_tick) begin
                frame_cnt_reg <= frame_cnt_reg + 1'b1;
            end
            if (state_reg == HOST_IDLE) begin
                int_due_reg <= 1'b0;
            end
        end
    end

    // packet sizing per link speed
    assign max_pkt = i_full_speed ? FS_MAX_PKT : LS_MAX_PKT;
    assign pkt_len_wide = (remain_reg > LEN_W'(max_pkt)) ?
        LEN_W'(max_pkt) : remain_reg;
    assign remain_next = remain_reg - pkt_len_wide;
    // interrupt polls never use the second buffer
    assign use_double = i_double_buf && !is_int_reg;

    // host transfer sequencer
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            state_reg <= HOST_IDLE;
            sel_reg <= 1'b0;
            is_int_reg <= 1'b0;
            remain_reg <= '0;
            o_pkt_valid <= 1'b0;
            o_pkt_len <= '0;
            o_buf_done <= 1'b0;
        end else begin
            o_buf_done <= 1'b0;
            case (state_reg)
                HOST_IDLE: begin
                    if (int_due_reg) begin
                        is_int_reg <= 1'b1;
                        sel_reg <= 1'b0;
                        state_reg <= HOST_FETCH;
                    end else if (i_host_start) begin
                        is_int_reg <= 1'b0;
                        if (!i_double_buf) begin
                            sel_reg <= 1'b0;
                        end
                        state_reg <= HOST_FETCH;
                    end
                end
                HOST_FETCH: begin
                    // single mode ignores the selector on fetch
                    if (use_double && sel_reg) begin
                        remain_reg <= i_buf_ctrl[HALF_W +: LEN_W];
                    end else begin
                        remain_reg <= i_buf_ctrl[LEN_W-1:0];
                    end
                    state_reg <= HOST_PACKET;
                end
                HOST_PACKET: begin
                    o_pkt_len <= pkt_len_wide[PKT_W-1:0];
                    o_pkt_valid <= !i_pkt_done;
                    if (i_pkt_done && o_pkt_valid) begin
                        remain_reg <= remain_next;
                        if (remain_next == '0) begin
                            state_reg <= HOST_DONE;
                        end
                    end
                end
                HOST_DONE: begin
                    o_buf_done <= 1'b1;
                    if (use_double) begin
                        sel_reg <= !sel_reg;
                    end
                    state_reg <= HOST_IDLE;
                end
                default: begin
                    state_reg <= HOST_IDLE;
                end
            endcase
        end
    end

    // status write-back; a completion wins over a clear in the same cycle
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_buf_status <= STATUS_RESET;
        end else if (state_reg == HOST_DONE) begin
            if (use_double && sel_reg) begin
                o_buf_status[HALF_W +: HALF_W] <= 16'h8000;
            end else begin
                o_buf_status[HALF_W-1:0] <= 16'h8000;
            end
        end else if (i_status_clear) begin
            o_buf_status <= STATUS_RESET;
        end
    end

    // selector captured at the moment the buffer is marked done
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_buffer_handling_selector_status <= 1'b0;
        end else if (state_reg == HOST_DONE) begin
            o_buffer_handling_selector_status <= sel_reg;
        end
    end

    // busy and kind flags for software
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_busy <= 1'b0;
            o_is_int <= 1'b0;
        end else begin
            o_busy <= state_reg != HOST_IDLE;
            o_is_int <= is_int_reg;
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);

    a_abort_naks: assert property (
        i_tok_valid && i_endpoint_abort_bits[i_tok_ep] |=>
        o_resp_valid && o_resp_nak)
        else $error("token on aborted endpoint not naked");
    a_abort_cancels: assert property (
        |i_endpoint_abort_bits |=>
        (o_ep_pending & $past(i_endpoint_abort_bits)) == '0)
        else $error("aborted endpoint still pending");
    a_no_lockup: assert property (
        i_tok_valid && !i_endpoint_abort_bits[i_tok_ep] &&
        pending_reg[i_tok_ep] |=> o_resp_valid && !o_resp_nak)
        else $error("armed endpoint naked");
    a_poll_starts: assert property (
        state_reg == HOST_IDLE && int_due_reg |=>
        state_reg == HOST_FETCH && is_int_reg)
        else $error("due interrupt poll not started");
    a_int_first_buf: assert property (
        state_reg == HOST_FETCH && is_int_reg |-> !sel_reg)
        else $error("interrupt transfer on second buffer");
    a_single_sel_fixed: assert property (
        !i_double_buf && state_reg == HOST_FETCH |-> !sel_reg)
        else $error("selector moved in single mode");
    a_pkt_size: assert property (
        o_pkt_valid |-> o_pkt_len <= (i_full_speed ? FS_MAX_PKT : LS_MAX_PKT))
        else $error("packet longer than speed limit");
    a_single_low_half: assert property (
        state_reg == HOST_DONE && !use_double |=>
        $stable(o_buf_status[31:16]))
        else $error("upper status half written in single mode");
    a_fetch_first: assert property (
        state_reg == HOST_FETCH && !use_double |=>
        remain_reg == $past(i_buf_ctrl[LEN_W-1:0]))
        else $error("single mode fetch used second buffer");
    a_handle_sel: assert property (
        state_reg == HOST_DONE |=> o_buf_done &&
        o_buffer_handling_selector_status == $past(sel_reg))
        else $error("selector not recorded at done");

    c_abort_token: cover property (
        i_tok_valid && i_endpoint_abort_bits[i_tok_ep]);
    c_int_done: cover property (state_reg == HOST_DONE && is_int_reg);
    c_second_done: cover property (
        state_reg == HOST_DONE && use_double && sel_reg);
    c_multi_packet: cover property (
        i_pkt_done && o_pkt_valid && remain_next != '0);
endmodule : usb_endpoint_buffer_control

// *** verification/usb_link_model.sv ***
// link-side model: finishes each packet request after a chosen wait
// assumes it shares the core clock and reset of the block
module usb_link_model (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // packet handshake
    input wire logic i_pkt_valid,
    input wire logic [3:0] i_wait,
    output logic o_pkt_done
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_reg;
    // one pulse per request; clearing on done stops a double answer
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n || !i_pkt_valid || o_pkt_done) begin
            wait_reg <= 4'h0;
            o_pkt_done <= 1'b0;
        end else if (wait_reg >= i_wait) begin
            o_pkt_done <= 1'b1;
        end else begin
            wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule : usb_link_model

// *** verification/usb_endpoint_buffer_control_tb_top.sv ***
// self-checking bench: device abort and host buffer selection
// assumes the link model answers every packet request
module usb_endpoint_buffer_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import usb_buf_pkg::*;
    localparam int POLL = 20;
    logic i_core_clk = 1'b0, i_reset_n = 1'b0, i_tok_valid = 1'b0;
    logic [NUM_EP-1:0] i_endpoint_abort_bits = '0, i_ep_arm = '0;
    logic [NUM_EP-1:0] o_ep_pending;
    logic [3:0] i_tok_ep = 4'h0, wt = 4'h0;
    logic i_full_speed = 1'b0, i_double_buf = 1'b0, i_int_enable = 1'b0;
    logic [7:0] i_int_interval = 8'h01;
    logic [31:0] i_buf_ctrl = 32'h0, o_buf_status;
    logic i_host_start = 1'b0, i_status_clear = 1'b0, i_pkt_done;
    logic o_resp_valid, o_resp_nak, o_pkt_valid, o_buf_done, o_busy;
    logic o_is_int, sel;
    logic [PKT_W-1:0] o_pkt_len;
    int err_total = 0, checked = 0, seed = 32'h2fdb, pkts, bytes, e, f, a, b;
    int lens[6] = '{0, 8, 9, 64, 65, 100};
    usb_endpoint_buffer_control #(.POLL_CYCLES(POLL))
        usb_endpoint_buffer_control_i (
        .i_core_clk, .i_reset_n, .i_endpoint_abort_bits, .i_ep_arm,
        .i_tok_valid, .i_tok_ep, .o_resp_valid, .o_resp_nak, .o_ep_pending,
        .i_full_speed, .i_double_buf, .i_int_enable, .i_int_interval,
        .i_buf_ctrl, .i_host_start, .i_status_clear, .o_pkt_valid,
        .o_pkt_len, .i_pkt_done, .o_buf_done, .o_busy, .o_is_int,
        .o_buf_status, .o_buffer_handling_selector_status(sel));
    usb_link_model usb_link_model_i (.i_core_clk, .i_reset_n,
        .i_pkt_valid(o_pkt_valid), .i_wait(wt), .o_pkt_done(i_pkt_done));
    // free-running 20 MHz clock
    initial forever #25 i_core_clk = ~i_core_clk;
    // count packets and bytes the link accepts
    always @(posedge i_core_clk) begin
        if (o_pkt_valid === 1'b1 && i_pkt_done === 1'b1) begin
            pkts++;
            bytes += o_pkt_len;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask : check
    // packets expected for a length at a link speed; zero length is one
    function automatic int exp_pkts(input int len, input logic fs);
        int mx;
        mx = fs ? int'(FS_MAX_PKT) : int'(LS_MAX_PKT);
        return (len == 0) ? 1 : (len + mx - 1) / mx;
    endfunction : exp_pkts
    task automatic close_out;
        $display("counts: %0d checked, %0d bad", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : close_out
    task automatic arm_ep(input int ep);
        @(posedge i_core_clk) i_ep_arm <= 16'h0001 << ep;
        @(posedge i_core_clk) i_ep_arm <= '0;
        #1;
    endtask : arm_ep
    // token one edge, answer checked in the cycle that follows
    task automatic tok(input int ep, input logic nak);
        @(posedge i_core_clk) i_tok_valid <= 1'b1;
        i_tok_ep <= ep[3:0];
        @(posedge i_core_clk) i_tok_valid <= 1'b0;
        #1;
        check(o_resp_valid, 1'b1);
        check(o_resp_nak, nak);
    endtask : tok
    // bounded wait: a lost completion must not hang the run
    task automatic wait_done(input int n);
        for (int k = 0; k < n; k++) begin
            @(posedge i_core_clk);
            #1;
            if (o_buf_done === 1'b1) break;
        end
        check(o_buf_done, 1'b1);
    endtask : wait_done
    task automatic xfer(input logic [31:0] c, input logic fs, input logic d,
                        input int len, input logic s);
        int np;
        np = exp_pkts(len, fs);
        @(posedge i_core_clk) i_status_clear <= 1'b1;
        i_buf_ctrl <= c;
        i_full_speed <= fs;
        i_double_buf <= d;
        wt <= 4'($random(seed) & 3);
        @(posedge i_core_clk) i_status_clear <= 1'b0;
        i_host_start <= 1'b1;
        pkts = 0;
        bytes = 0;
        @(posedge i_core_clk) i_host_start <= 1'b0;
        wait_done(3000);
        check(pkts, np);
        check(bytes, len);
        check(o_buf_status, s ? 32'h8000_0000 : 32'h0000_8000);
        check(sel, s);
        check(o_is_int, 1'b0);
        check(o_busy, 1'b1);
        // busy falls one cycle after the done pulse
        @(posedge i_core_clk);
        #1;
        check(o_busy, 1'b0);
        $display("transfer of %0d bytes ended", len);
    endtask : xfer
    initial begin
        repeat (15) @(posedge i_core_clk);
        #1;
        check({o_resp_valid, o_pkt_valid, o_buf_done, o_busy, sel}, 0);
        check(o_buf_status, STATUS_RESET);
        @(posedge i_core_clk) i_reset_n <= 1'b1;
        // abort on one endpoint must leave the others answering
        for (int i = 0; i < 6; i++) begin
            e = $random(seed) & 15;
            f = (e + 1 + ($random(seed) & 7)) & 15;
            arm_ep(e);
            check(o_ep_pending[e], 1'b1);
            tok(e, 1'b0);
            tok(e, 1'b1);
            arm_ep(e);
            arm_ep(f);
            @(posedge i_core_clk) i_endpoint_abort_bits <= 16'h0001 << e;
            repeat (2) @(posedge i_core_clk);
            #1;
            check(o_ep_pending[e], 1'b0);
            tok(e, 1'b1);
            tok(f, 1'b0);
            check(o_ep_pending[f], 1'b0);
            @(posedge i_core_clk) i_endpoint_abort_bits <= '0;
        end
        $display("device abort tests ended");
        // single mode: corners then random, second field is a decoy
        for (int i = 0; i < 12; i++) begin
            a = (i < 6) ? lens[i] : ($random(seed) & 511);
            b = ($random(seed) & 511) | 1;
            xfer({6'h0, b[9:0], 6'h0, a[9:0]}, i < 6 ? i > 2 : a[0],
                 1'b0, a, 1'b0);
        end
        // double mode: three transfers leave the selector on the second
        a = 70;
        b = 130;
        for (int i = 0; i < 3; i++) begin
            xfer({6'h0, b[9:0], 6'h0, a[9:0]}, 1'b1, 1'b1, i[0] ? b : a,
                 i[0]);
        end
        // interrupt poll must complete against the first buffer
        pkts = 0;
        bytes = 0;
        @(posedge i_core_clk) i_int_enable <= 1'b1;
        i_status_clear <= 1'b1;
        @(posedge i_core_clk) i_status_clear <= 1'b0;
        wait_done(POLL * 4 + 500);
        i_int_enable <= 1'b0;
        check(o_is_int, 1'b1);
        check(sel, 1'b0);
        check(o_buf_status, 32'h0000_8000);
        check(bytes, a);
        check(pkts, exp_pkts(a, 1'b1));
        $display("interrupt poll test ended");
        close_out();
    end
    // watchdog sized well beyond the longest expected run
    initial begin
        #(50 * 60000);
        err_total++;
        close_out();
    end
endmodule : usb_endpoint_buffer_control_tb_top
